//--- rwt_pkg.sv
// Package of the runaway timer: register map, field layout, codes.
// Assumes a 32-bit APB master and a 200 MHz system clock.
`default_nettype none

package rwt_pkg;

  // --------------------------------------------------------------
  // Register byte offsets
  // --------------------------------------------------------------
  localparam logic [11:0] MODE_OFS = 12'h000;
  localparam logic [11:0] CODE_OFS = 12'h004;
  localparam logic [11:0] STAT_OFS = 12'h008;
  localparam logic [11:0] MASK_OFS = 12'h00c;
  localparam logic [11:0] STATE_OFS = 12'h010;

  // --------------------------------------------------------------
  // Mode register fields
  // --------------------------------------------------------------
  localparam int ENABLE_POS = 7;
  localparam int TIME_LSB = 4;
  localparam int TIME_W = 3;
  localparam int IDLE_POS = 2;
  localparam int ACTION_POS = 1;
  localparam logic [7:0] MODE_RESET = 8'h82;
  localparam logic [7:0] MODE_WR_MASK = 8'hf7;

  // --------------------------------------------------------------
  // Codes, detection times, reset hold
  // --------------------------------------------------------------
  localparam logic [7:0] DISABLE_CODE = 8'hb1;
  localparam logic [7:0] CLEAR_CODE = 8'h4e;
  localparam int SHORT_SHIFT = 15;
  localparam int TIME_STEP = 2;
  localparam int TIME_CODES = 6;
  localparam int RESET_HOLD_STATES = 32;

  // --------------------------------------------------------------
  // Event status bits
  // --------------------------------------------------------------
  localparam int EVT_W = 2;
  localparam int EVT_EXPIRY = 0;
  localparam int EVT_BADCODE = 1;
  localparam logic [1:0] EVT_RESET = 2'h0;

endpackage

`default_nettype wire

//--- rwt_sync2.sv
// Two-stage synchroniser for level inputs.
// Assumes inputs may come from outside the clock domain.
`timescale 1ns/1ps
`default_nettype none

module rwt_sync2 #(
  parameter int W = 2
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic sys_rst_i,
  // Levels
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } rwt_sync_t;

  rwt_sync_t st_q;
  rwt_sync_t st_d;

  // First stage feeds only the second
  always_comb begin
    st_d.s1 = async_i;
    st_d.s2 = st_q.s1;
  end

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign sync_o = st_q.s2;

endmodule // rwt_sync2

`default_nettype wire

//--- rwt_rst_hold.sv
// Stretches an expiry pulse into a reset held for a fixed count.
// Assumes start_i is a one-cycle pulse on clock_i.
`timescale 1ns/1ps
`default_nettype none

module rwt_rst_hold #(
  parameter int HOLD = rwt_pkg::RESET_HOLD_STATES
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic sys_rst_i,
  // Trigger and held level
  input wire logic start_i,
  output logic active_o
);

  typedef struct packed {
    logic act;
    logic [7:0] cnt;
  } rwt_hold_t;

  rwt_hold_t st_q;
  rwt_hold_t st_d;

  // Counts down HOLD cycles of active level
  always_comb begin
    st_d = st_q;
    if (start_i) begin
      st_d.act = 1'b1;
      st_d.cnt = 8'(HOLD - 1);
    end else if (st_q.act) begin
      if (st_q.cnt == 8'h00) begin
        st_d.act = 1'b0;
      end else begin
        st_d.cnt = st_q.cnt - 8'h01;
      end
    end
  end

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign active_o = st_q.act;

endmodule // rwt_rst_hold

`default_nettype wire

//--- rwt_timer.sv
// Runaway timer top: APB registers, counter, expiry actions.
// Assumes idle and debug levels may be asynchronous to clock_i.
//
// The APB register port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Expiry raises timeout request or reset
// - Timeout request is non-maskable output
// - No external alarm pin provided
// - Mode bit 7 enables, resets to one
// - Disable needs enable cleared then code
// - Setting enable bit resumes counting
// - Bits 6-4 select detection time
// - Idle run bit controls idle counting
// - Action bit chooses interrupt or reset
// - Mode at 0x0, code entry at 0x4
// - Clear code restarts counter from zero
// - Counter runs immediately after reset
// - Reset held 32 states after overflow
// - Counter halts in debug mode
module rwt_timer #(
  parameter int SHORT_SHIFT = rwt_pkg::SHORT_SHIFT
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic sys_rst_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Processor state
  input wire logic idle_i,
  input wire logic debug_i,
  // Expiry outputs
  output logic timeout_irq_o,
  output logic expiry_reset_o,
  // Maskable event interrupt
  output logic irq_o
);

  // --------------------------------------------------------------
  // Types and state
  // --------------------------------------------------------------
  localparam int CNT_W = SHORT_SHIFT
    + rwt_pkg::TIME_STEP * (rwt_pkg::TIME_CODES - 1);

  typedef struct packed {
    logic [7:0] mode;
    logic disabled;
    logic [CNT_W-1:0] cnt;
    logic nmi;
    logic [rwt_pkg::EVT_W-1:0] stat;
    logic [rwt_pkg::EVT_W-1:0] mask;
    logic [31:0] rdata;
  } rwt_state_t;

  rwt_state_t st_q;
  rwt_state_t st_d;

  // Address match on the word index
  function automatic logic hit(input logic [11:0] a,
                               input logic [11:0] ofs);
    return a[11:2] == ofs[11:2];
  endfunction

  // Detection code to last count; reserved codes take the longest
  function automatic logic [CNT_W-1:0] last_of(
      input logic [rwt_pkg::TIME_W-1:0] code);
    int sel;
    int shift;
    sel = int'(code);
    if (sel >= rwt_pkg::TIME_CODES) begin
      sel = rwt_pkg::TIME_CODES - 1;
    end
    shift = SHORT_SHIFT + rwt_pkg::TIME_STEP * sel;
    return CNT_W'((64'h1 << shift) - 64'h1);
  endfunction

  // --------------------------------------------------------------
  // Input synchronisers and reset stretcher
  // --------------------------------------------------------------
  logic [1:0] proc_s;
  logic idle_s;
  logic debug_s;
  logic expire;
  logic hold_act;

  rwt_sync2 #(
    .W(2)
  ) u_sync (
    .clock_i(clock_i),
    .sys_rst_i(sys_rst_i),
    .async_i({debug_i, idle_i}),
    .sync_o(proc_s)
  );

  assign idle_s = proc_s[0];
  assign debug_s = proc_s[1];

  // Reset expiry action feeds the stretcher
  rwt_rst_hold #(
    .HOLD(rwt_pkg::RESET_HOLD_STATES)
  ) u_hold (
    .clock_i(clock_i),
    .sys_rst_i(sys_rst_i),
    .start_i(expire && st_q.mode[rwt_pkg::ACTION_POS]),
    .active_o(hold_act)
  );

  // --------------------------------------------------------------
  // Bus decode
  // --------------------------------------------------------------
  logic acc;
  logic wr;
  logic rd_setup;
  logic mapped;
  logic wr_mode;
  logic wr_code;
  logic wr_stat;
  logic wr_mask;
  logic [7:0] code;
  logic run;
  logic [CNT_W-1:0] last_cnt;
  logic [rwt_pkg::EVT_W-1:0] evt;
  logic [rwt_pkg::EVT_W-1:0] w1c;

  // Zero wait states: read data is latched in the setup cycle
  assign acc = psel_i && penable_i;
  assign wr = acc && pwrite_i;
  assign rd_setup = psel_i && !penable_i && !pwrite_i;
  assign mapped = hit(paddr_i, rwt_pkg::MODE_OFS)
    || hit(paddr_i, rwt_pkg::CODE_OFS)
    || hit(paddr_i, rwt_pkg::STAT_OFS)
    || hit(paddr_i, rwt_pkg::MASK_OFS)
    || hit(paddr_i, rwt_pkg::STATE_OFS);
  assign wr_mode = wr && hit(paddr_i, rwt_pkg::MODE_OFS);
  assign wr_code = wr && hit(paddr_i, rwt_pkg::CODE_OFS);
  assign wr_stat = wr && hit(paddr_i, rwt_pkg::STAT_OFS);
  assign wr_mask = wr && hit(paddr_i, rwt_pkg::MASK_OFS);
  assign code = pwdata_i[7:0];
  assign pready_o = 1'b1;
  assign pslverr_o = acc && !mapped;
  assign prdata_o = st_q.rdata;

  // --------------------------------------------------------------
  // Counter control
  // --------------------------------------------------------------
  // Counting stops while disabled, in debug, idle without the
  // idle run bit, and while the expiry reset is being held.
  assign run = !st_q.disabled
    && !debug_s
    && (!idle_s || st_q.mode[rwt_pkg::IDLE_POS])
    && !hold_act;

  assign last_cnt = last_of(
    st_q.mode[rwt_pkg::TIME_LSB +: rwt_pkg::TIME_W]);
  assign expire = run && (st_q.cnt == last_cnt);

  // Events for the maskable status register
  always_comb begin
    evt = '0;
    evt[rwt_pkg::EVT_EXPIRY] = expire;
    evt[rwt_pkg::EVT_BADCODE] = wr_code
      && (code != rwt_pkg::CLEAR_CODE)
      && !((code == rwt_pkg::DISABLE_CODE)
           && !st_q.mode[rwt_pkg::ENABLE_POS]);
    w1c = wr_stat ? pwdata_i[rwt_pkg::EVT_W-1:0] : '0;
  end

  // --------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------
  always_comb begin
    st_d = st_q;

    // Mode register; bit 3 is held at zero
    if (wr_mode) begin
      st_d.mode = code & rwt_pkg::MODE_WR_MASK;
      if (code[rwt_pkg::ENABLE_POS]) begin
        st_d.disabled = 1'b0;
      end
    end

    // Binary counter with wrap at the detection limit
    if (expire) begin
      st_d.cnt = '0;
    end else if (run) begin
      st_d.cnt = st_q.cnt + CNT_W'(1);
    end

    // Code entry; other values fall through untouched
    if (wr_code && code == rwt_pkg::CLEAR_CODE) begin
      st_d.cnt = '0;
      st_d.nmi = 1'b0;
    end else if (wr_code && code == rwt_pkg::DISABLE_CODE
                 && !st_q.mode[rwt_pkg::ENABLE_POS]) begin
      st_d.disabled = 1'b1;
      st_d.cnt = '0;
    end

    // Timeout request; a new expiry beats a clear
    if (expire && !st_q.mode[rwt_pkg::ACTION_POS]) begin
      st_d.nmi = 1'b1;
    end

    // Sticky status, set wins over write-one-to-clear
    st_d.stat = (st_q.stat & ~w1c) | evt;
    if (wr_mask) begin
      st_d.mask = pwdata_i[rwt_pkg::EVT_W-1:0];
    end

    // Read data captured in the setup cycle
    if (rd_setup) begin
      st_d.rdata = 32'h0000_0000;
      if (hit(paddr_i, rwt_pkg::MODE_OFS)) begin
        st_d.rdata[7:0] = st_q.mode;
      end else if (hit(paddr_i, rwt_pkg::STAT_OFS)) begin
        st_d.rdata[rwt_pkg::EVT_W-1:0] = st_q.stat;
      end else if (hit(paddr_i, rwt_pkg::MASK_OFS)) begin
        st_d.rdata[rwt_pkg::EVT_W-1:0] = st_q.mask;
      end else if (hit(paddr_i, rwt_pkg::STATE_OFS)) begin
        st_d.rdata[0] = !st_q.disabled;
        st_d.rdata[1] = st_q.nmi;
        st_d.rdata[2] = hold_act;
      end
    end
  end

  // --------------------------------------------------------------
  // State register
  // --------------------------------------------------------------
  // Counter starts from zero and runs as soon as reset drops
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_q.mode <= rwt_pkg::MODE_RESET;
      st_q.disabled <= 1'b0;
      st_q.cnt <= '0;
      st_q.nmi <= 1'b0;
      st_q.stat <= rwt_pkg::EVT_RESET;
      st_q.mask <= rwt_pkg::EVT_RESET;
      st_q.rdata <= 32'h0000_0000;
    end else begin
      st_q <= st_d;
    end
  end

  // --------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------
  // Timeout request bypasses the mask: it is the non-maskable line.
  // There is deliberately no alarm pin on this variant.
  assign timeout_irq_o = st_q.nmi;
  assign expiry_reset_o = hold_act;
  assign irq_o = |(st_q.stat & st_q.mask);

  // --------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (sys_rst_i);

  sequence s_code(logic [7:0] c);
    wr_code && code == c;
  endsequence

  sequence s_enable_off;
    !st_q.mode[rwt_pkg::ENABLE_POS] && !st_q.disabled;
  endsequence

  sequence s_reset_pulse;
    expiry_reset_o [*8] ##0 1'b1 ##24 expiry_reset_o ##1 !expiry_reset_o;
  endsequence

  a_expiry_nmi: assert property (
    expire && !st_q.mode[rwt_pkg::ACTION_POS]
    |=> timeout_irq_o && !expiry_reset_o)
    else $error("expiry did not raise timeout request");

  a_nmi_unmasked: assert property (
    expire && !st_q.mode[rwt_pkg::ACTION_POS] && st_q.mask == '0
    |=> timeout_irq_o && !irq_o)
    else $error("timeout request depends on mask");

  a_enable_resume: assert property (
    wr_mode && code[rwt_pkg::ENABLE_POS]
    |=> !st_q.disabled)
    else $error("enable bit did not resume counting");

  a_disable_steps: assert property (
    s_enable_off ##0 s_code(rwt_pkg::DISABLE_CODE)
    |=> st_q.disabled && st_q.cnt == '0)
    else $error("two-step disable failed");

  a_disable_guard: assert property (
    st_q.mode[rwt_pkg::ENABLE_POS] && !st_q.disabled
    ##0 s_code(rwt_pkg::DISABLE_CODE)
    |=> !st_q.disabled)
    else $error("disable code took effect while enabled");

  a_expire_limit: assert property (
    expire |-> st_q.cnt == last_cnt ##1 st_q.cnt == '0)
    else $error("expiry at wrong count");

  a_idle_stop: assert property (
    idle_s && !st_q.mode[rwt_pkg::IDLE_POS] && !wr_code
    |=> $stable(st_q.cnt))
    else $error("counter moved in idle");

  a_reset_hold: assert property (
    expire && st_q.mode[rwt_pkg::ACTION_POS]
    |=> s_reset_pulse)
    else $error("reset not held for 32 states");

  a_clear_zero: assert property (
    s_code(rwt_pkg::CLEAR_CODE)
    |=> st_q.cnt == '0 && !timeout_irq_o)
    else $error("clear code did not restart counter");

  a_debug_halt: assert property (
    debug_s && !wr_code |=> $stable(st_q.cnt))
    else $error("counter moved in debug");

  a_mode_zeros: assert property (
    rd_setup && hit(paddr_i, rwt_pkg::MODE_OFS)
    |=> prdata_o[31:8] == 24'h000000 && !prdata_o[3])
    else $error("reserved mode bits not zero");

  a_junk_code: assert property (
    wr_code && code != rwt_pkg::CLEAR_CODE
    && code != rwt_pkg::DISABLE_CODE
    |=> $stable(st_q.disabled) && $stable(timeout_irq_o))
    else $error("unknown code changed state");

endmodule // rwt_timer

`default_nettype wire

//--- watchdog_timer_bench.sv
// Self-checking bench of the runaway timer, with a small register model.
// Assumes rwt_pkg and rwt_timer are compiled first; SHORT_SHIFT is cut to 4.
`timescale 1ns/1ps
`default_nettype none

module watchdog_timer_bench;
  localparam int SH = 4;
  logic clock_i = 0;
  logic sys_rst_i = 1;
  logic psel_i = 0;
  logic penable_i = 0;
  logic pwrite_i = 0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0;
  logic idle_i = 0;
  logic debug_i = 0;
  logic [31:0] prdata_o;
  logic pready_o;
  logic pslverr_o;
  logic timeout_irq_o;
  logic expiry_reset_o;
  logic irq_o;
  logic err_q;
  logic [31:0] rd_q;
  int n_fail = 0;
  int compares = 0;
  int n;
  int mode_m;
  int stat_m;
  logic [31:0] rnd = 32'h57;

  rwt_timer #(.SHORT_SHIFT(SH)) DUT (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .idle_i(idle_i), .debug_i(debug_i),
    .timeout_irq_o(timeout_irq_o), .expiry_reset_o(expiry_reset_o), .irq_o(irq_o));

  // --------------------------------------------------------------
  // Clock, helpers
  // --------------------------------------------------------------
  always #2.5 clock_i = ~clock_i;

  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    if (n_fail == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // One APB transfer; holds the request until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge clock_i);
    psel_i <= 1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clock_i);
    penable_i <= 1;
    k = 0;
    do begin
      @(posedge clock_i);
      k++;
    end while (pready_o !== 1'b1 && k < 50);
    rd_q = prdata_o;
    err_q = pslverr_o;
    psel_i <= 0;
    penable_i <= 0;
    if (w && a == rwt_pkg::MODE_OFS) mode_m = d & 32'hf7;
    if (w && a == rwt_pkg::STAT_OFS) stat_m = stat_m & ~d;
    // Let the edge's register updates settle before anyone looks
    @(negedge clock_i);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rd_q, exp);
  endtask

  // Counts cycles until the chosen expiry output is high, at most lim
  task automatic wait_out(input bit rst, input int lim);
    n = 0;
    while (n < lim && (rst ? expiry_reset_o : timeout_irq_o) !== 1'b1) begin
      @(negedge clock_i);
      n++;
    end
  endtask

  task automatic win(input int exp);
    check(n >= exp - 2 && n <= exp + 3, 1'b1);
  endtask

  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial begin
    stat_m = 0;
    repeat (2) @(posedge clock_i);
    sys_rst_i <= 0;
    wait_out(1, 100);
    win(2 ** SH);
    n = 0;
    while (expiry_reset_o === 1'b1 && n < 100) begin
      @(negedge clock_i);
      n++;
    end
    check(n, 32);
    mode_m = 32'h82;
    rd(rwt_pkg::MODE_OFS, mode_m);
    rd(rwt_pkg::CODE_OFS, 32'h0);
    rd(12'h014, 32'h0);
    check(err_q, 1'b1);
    rnd = xs(rnd);
    apb(1'b1, rwt_pkg::MODE_OFS, {rnd[31:8], 4'h8, rnd[3:2], 2'b00} | 32'h9);
    rd(rwt_pkg::MODE_OFS, mode_m);
    apb(1'b1, rwt_pkg::STAT_OFS, 32'h3);
    stat_m = 0;
    // Detection time codes 0 to 6, reserved code 6 acts as the longest
    for (int c = 0; c < 7; c++) begin
      apb(1'b1, rwt_pkg::MODE_OFS, 32'h80 | (c << 4));
      apb(1'b1, rwt_pkg::CODE_OFS, 32'h4e);
      wait_out(0, 40000);
      win(2 ** (SH + 2 * (c > 5 ? 5 : c)));
      check(irq_o, 1'b0);
      stat_m = stat_m | 1;
      apb(1'b1, rwt_pkg::CODE_OFS, 32'h4e);
      check(timeout_irq_o, 1'b0);
    end
    rd(rwt_pkg::STAT_OFS, stat_m);
    apb(1'b1, rwt_pkg::MASK_OFS, 32'h1);
    @(negedge clock_i);
    check(irq_o, 1'b1);
    apb(1'b1, rwt_pkg::STAT_OFS, 32'h1);
    @(negedge clock_i);
    check(irq_o, 1'b0);
    // Regular clears keep the shortest time from running out
    apb(1'b1, rwt_pkg::MODE_OFS, 32'h80);
    repeat (12) begin
      apb(1'b1, rwt_pkg::CODE_OFS, 32'h4e);
      repeat (6) @(posedge clock_i);
    end
    check(timeout_irq_o, 1'b0);
    // Disable code while enabled and a random code are both ignored
    apb(1'b1, rwt_pkg::CODE_OFS, 32'h4e);
    apb(1'b1, rwt_pkg::CODE_OFS, 32'hb1);
    do rnd = xs(rnd); while (rnd[7:0] == 8'hb1 || rnd[7:0] == 8'h4e);
    apb(1'b1, rwt_pkg::CODE_OFS, {24'h0, rnd[7:0]});
    wait_out(0, 40);
    check(n <= 2 ** SH - 4, 1'b1);
    stat_m = stat_m | 3;
    rd(rwt_pkg::STAT_OFS, stat_m);
    // Disable takes both steps, enable takes one
    apb(1'b1, rwt_pkg::MODE_OFS, 32'h00);
    apb(1'b1, rwt_pkg::CODE_OFS, 32'hb1);
    apb(1'b1, rwt_pkg::CODE_OFS, 32'h4e);
    wait_out(0, 200);
    check(timeout_irq_o, 1'b0);
    rd(rwt_pkg::STATE_OFS, 32'h0);
    apb(1'b1, rwt_pkg::MODE_OFS, 32'h80);
    wait_out(0, 40);
    win(2 ** SH);
    // Debug halts the counter
    @(posedge clock_i);
    debug_i <= 1;
    apb(1'b1, rwt_pkg::CODE_OFS, 32'h4e);
    wait_out(0, 200);
    check(timeout_irq_o, 1'b0);
    @(posedge clock_i);
    debug_i <= 0;
    wait_out(0, 40);
    check(timeout_irq_o, 1'b1);
    rd(rwt_pkg::STATE_OFS, 32'h3);
    // Idle stops the counter unless the idle run bit is set
    @(posedge clock_i);
    idle_i <= 1;
    apb(1'b1, rwt_pkg::CODE_OFS, 32'h4e);
    wait_out(0, 200);
    check(timeout_irq_o, 1'b0);
    apb(1'b1, rwt_pkg::MODE_OFS, 32'h84);
    wait_out(0, 40);
    check(timeout_irq_o, 1'b1);
    @(posedge clock_i);
    idle_i <= 0;
    report_and_stop();
  end

  // Watchdog: the whole run needs about 39k cycles
  initial begin
    #(5 * 100000);
    n_fail++;
    report_and_stop();
  end
endmodule // watchdog_timer_bench

`default_nettype wire
